// ---- shared/rvac_map.vh ----
// Register map, field positions and timing constants of the refill controller
`ifndef RVAC_MAP_VH
`define RVAC_MAP_VH

// Register word addresses (byte offsets)
`define RVAC_A_CTRL 8'h00
`define RVAC_A_VALVE 8'h04
`define RVAC_A_START 8'h08
`define RVAC_A_STOP 8'h0c
`define RVAC_A_TMO 8'h10
`define RVAC_A_ALM1 8'h14
`define RVAC_A_ALM2 8'h18
`define RVAC_A_STAT 8'h1c
`define RVAC_A_CAUSE 8'h20

// Control register fields
`define RVAC_C_DUAL 0
`define RVAC_C_SINGLE 1
`define RVAC_C_FILLCH 2
`define RVAC_C_MUTE 3

// Valve command fields
`define RVAC_V_STEP 0
`define RVAC_V_COMMIT 1

// Alarm configuration fields
`define RVAC_L_SRC 16
`define RVAC_L_DIR 17

// Read-back field positions (low bit of each field)
`define RVAC_F_MODE 0
`define RVAC_F_SEL 4
`define RVAC_S_VALVE 2
`define RVAC_S_RELAY1 3
`define RVAC_S_RELAY2 4
`define RVAC_S_TMO 5
`define RVAC_S_BUZZ 6
`define RVAC_S_MUTE 7
`define RVAC_S_VIEW 8
`define RVAC_S_MIN 16
`define RVAC_Q_ALM1 0
`define RVAC_Q_ALM2 4
`define RVAC_Q_TMO 8

// Valve control states
`define RVAC_M_CLOSED 2'h0
`define RVAC_M_AUTO 2'h1
`define RVAC_M_OPEN 2'h2
`define RVAC_M_TCLOSED 2'h3

// Channel codes
`define RVAC_CH_N2 1'b0
`define RVAC_CH_HE 1'b1

// Cause codes; muted is a display-only code
`define RVAC_K_NONE 3'h0
`define RVAC_K_LOW 3'h1
`define RVAC_K_HIGH 3'h2
`define RVAC_K_TMO 3'h3
`define RVAC_K_MUTED 3'h4

// Reset values
`define RVAC_R_CTRL 4'h1
`define RVAC_R_LVL 16'h0000
`define RVAC_R_DUAL 1'b1
`define RVAC_R_TMO 16'h0000

// Timing: minute length, display blink period, clock rate
`define RVAC_CLK_HZ 40'd200000000
`define RVAC_MINUTE_S 40'd60
`define RVAC_BLINK_MS 40'd500
`define RVAC_MS_PER_S 40'd1000

`endif

// ---- sim/rvac_monitor.sv ----
// Port-level assertion checker for the refill valve controller
`default_nettype none
module rvac_monitor #(
  parameter LW = 16,
  parameter [39:0] MIN_CYCLES = 40'd20
) (
  input wire mclk,
  input wire arst_n,
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  input wire [31:0] rdata,
  input wire [LW-1:0] lvl_n2,
  input wire [LW-1:0] lvl_he,
  input wire valve_pwr,
  input wire relay1,
  input wire relay2,
  input wire buzzer
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  logic [3:0] ctl;
  logic [1:0] sh_sel;
  logic sh_auto;
  logic [17:0] a1, a2;
  logic [15:0] tmo;
  logic [1:0] rc;
  logic [39:0] oc;
  // Alarm compare; all inputs passed so the assign sees every change
  function automatic logic hit(input logic [17:0] a, input logic [3:0] c,
      input logic [LW-1:0] n2, he);
    logic [LW-1:0] lv;
    lv = (c[0] ? a[16] : c[1]) ? he : n2;
    return a[17] ? lv >= a[15:0] : lv <= a[15:0];
  endfunction
  wire c1 = hit(a1, ctl, lvl_n2, lvl_he);
  wire c2 = hit(a2, ctl, lvl_n2, lvl_he);
  // Slack of a few cycles covers the prescaler and output register
  wire [39:0] lim = tmo * MIN_CYCLES + 40'd4;
  // Selector step order; timeout-closed and auto both step to open
  wire [1:0] nsel = !wdata[0] ? sh_sel : (sh_sel == 2'h0) ? 2'h1 :
    (sh_sel == 2'h2) ? 2'h0 : 2'h2;
  wire nfill = ctl[0] ? ctl[2] : ctl[1];
  // Shadow settings; rc says the synchronised reset has let go
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ctl <= 4'h1;
      a1 <= 18'h0;
      a2 <= 18'h0;
      tmo <= 16'h0;
      rc <= 2'h0;
      oc <= 40'h0;
      sh_sel <= 2'h0;
      sh_auto <= 1'b0;
    end else begin
      rc <= (rc == 2'h3) ? rc : rc + 2'h1;
      oc <= (valve_pwr && sh_auto && !(wr_stb && (addr == 8'h10 ||
          addr == 8'h04))) ? oc + 40'h1 : 40'h0;
      if (wr_stb) begin
        case (addr)
          8'h00: ctl <= wdata[3:0];
          8'h10: tmo <= wdata[15:0];
          8'h14: a1 <= wdata[17:0];
          8'h18: a2 <= wdata[17:0];
          default: ;
        endcase
      end
      if (wr_stb && (addr == 8'h08 || addr == 8'h0c || addr == 8'h10)) begin
        sh_sel <= 2'h0;
        sh_auto <= 1'b0;
      end else if (wr_stb && addr == 8'h04) begin
        sh_sel <= nsel;
        if (wdata[1]) begin
          sh_auto <= (nsel == 2'h1);
        end
      end
    end
  end
  sequence s_rise;
    !relay1 && !relay2 ##1 (relay1 || relay2);
  endsequence
  sequence s_pw;
    wr_stb && (addr == 8'h08 || addr == 8'h0c || addr == 8'h10);
  endsequence
  sequence s_mute;
    wr_stb && addr == 8'h00 && wdata[3];
  endsequence
  chk_relay_one: assert property (rc == 2'h3 |-> relay1 == $past(c1))
    else $error("relay1 differs from alarm 1 compare");
  chk_relay_two: assert property (rc == 2'h3 |-> relay2 == $past(c2))
    else $error("relay2 differs from alarm 2 compare");
  chk_buzz_alarm: assert property (s_rise |-> buzzer)
    else $error("alarm raised without buzzer");
  chk_mute_quiet: assert property (s_mute |-> ##[1:2] !buzzer)
    else $error("buzzer still on after mute");
  chk_param_close: assert property (
      s_pw ##1 !(wr_stb && addr == 8'h04) [*2] |=> !valve_pwr)
    else $error("valve powered after parameter write");
  chk_wd_bound: assert property (
      valve_pwr && sh_auto && tmo != 16'h0 && !nfill |-> oc <= lim)
    else $error("valve open past the refill timeout");
  chk_read_idle: assert property (!rd_stb |=> rdata == 32'h0)
    else $error("read data outside the read cycle");
  chk_reset_hold: assert property ($rose(arst_n) |->
      !valve_pwr && !buzzer && !relay1 ##1 !valve_pwr && !buzzer)
    else $error("outputs active just after reset");
endmodule // rvac_monitor
`default_nettype wire

// ---- sim/rvac_plant.sv ----
// Dewar model: nitrogen level rises while the fill valve is powered
`default_nettype none
module rvac_plant #(
  parameter LW = 16
) (
  input wire logic mclk,
  input wire logic valve_pwr,
  input wire logic load,
  input wire logic [LW-1:0] set_lvl,
  output logic [LW-1:0] lvl
);
  timeunit 1ns;
  timeprecision 1ps;
  // No boil-off: a closed valve holds the level so compares stay steady
  always @(posedge mclk) begin
    if (load) begin
      lvl <= set_lvl;
    end else if (valve_pwr) begin
      lvl <= lvl + {{(LW-1){1'b0}}, 1'b1};
    end
  end
endmodule // rvac_plant
`default_nettype wire

// ---- sim/testbench.sv ----
// Self-checking bench for the refill valve controller
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MINC = 20;
  logic mclk = 1'b0, arst_n = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0;
  logic rd_d = 1'b0, load = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, d1, d2, cf;
  logic [15:0] set_lvl = 16'h0032, lvl_he = 16'h0;
  logic [2:0] k1, k2;
  wire [31:0] rdata;
  wire [15:0] lvl_n2;
  wire valve_pwr, relay1, relay2, buzzer;
  logic [31:0] exp_q[$], msk_q[$], got[$];
  int n_mismatch = 0, samples_checked = 0, seed = 32'h0901, t;
  always #2.5 mclk = ~mclk;
  rvac_top #(.MIN_CYCLES(40'd20), .BLINK_CYCLES(40'd8)) u_rvac_top (
    .mclk, .arst_n, .addr, .wdata, .wr_stb, .rd_stb, .rdata, .lvl_n2,
    .lvl_he, .valve_pwr, .relay1, .relay2, .buzzer);
  rvac_plant u_rvac_plant (.mclk, .valve_pwr, .load, .set_lvl, .lvl(lvl_n2));
  task automatic cmp_rd(input logic [31:0] e, m);
    samples_checked++;
    if ((rdata & m) !== (e & m)) begin
      n_mismatch++;
      $display("FAIL rdata exp %h got %h", e & m, rdata & m);
    end
  endtask
  task automatic cmp_pin(input string nm, input logic e, g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("FAIL %s exp %b got %b", nm, e, g);
    end
  endtask
  // Read data stand only in the cycle after the strobe
  always @(posedge mclk) begin
    rd_d <= rd_stb;
    if (rd_d) begin
      got.push_back(rdata);
      cmp_rd(exp_q.pop_front(), msk_q.pop_front());
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
    @(posedge mclk);
    addr <= a;
    rd_stb <= 1'b1;
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge mclk);
    rd_stb <= 1'b0;
  endtask
  task automatic setlv(input logic [15:0] n2, he);
    @(posedge mclk);
    set_lvl <= n2;
    lvl_he <= he;
    load <= 1'b1;
    @(posedge mclk);
    load <= 1'b0;
  endtask
  // Bounded wait, sampled mid-cycle once the outputs have settled
  task automatic wait_pwr(input logic v, output int n);
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (valve_pwr !== v && n < 400);
  endtask
  function automatic logic [2:0] code(input logic [17:0] a,
      input logic [3:0] c, input logic [15:0] n2, he);
    logic [15:0] lv;
    lv = (c[0] ? a[16] : c[1]) ? he : n2;
    if (a[17]) return (lv >= a[15:0]) ? 3'h2 : 3'h0;
    return (lv <= a[15:0]) ? 3'h1 : 3'h0;
  endfunction
  task automatic finish_test();
    $display("n_mismatch %0d samples_checked %0d", n_mismatch,
      samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Hang guard, well past the several hundred cycles the run needs
  initial begin
    #100000;
    n_mismatch++;
    finish_test();
  end
  initial begin
    repeat (3) @(posedge mclk);
    arst_n <= 1'b1;
    load <= 1'b0;
    repeat (3) @(posedge mclk);
    rd(8'h00, 32'h1, 32'hffffffff);
    rd(8'h24, 32'h0, 32'hffffffff);
    wr(8'h08, 32'd100);
    wr(8'h0c, 32'd200);
    wr(8'h10, 32'd0);
    rd(8'h04, 32'h0, 32'h33);
    wr(8'h04, 32'h3);
    wait_pwr(1'b1, t);
    cmp_pin("open_delay", 1'b1, t <= 3);
    wait_pwr(1'b0, t);
    cmp_pin("stop_level", 1'b1, lvl_n2 >= 16'd200 && lvl_n2 <= 16'd202);
    rd(8'h1c, 32'h1, 32'h27);
    setlv(16'd150, 16'h0);
    repeat (4) @(negedge mclk);
    cmp_pin("valve_band", 1'b0, valve_pwr);
    setlv(16'd100, 16'h0);
    wait_pwr(1'b1, t);
    cmp_pin("open_start", 1'b1, t <= 3);
    wr(8'h10, 32'd2);
    setlv(16'd50, 16'h0);
    wr(8'h04, 32'h3);
    for (int j = 0; j < 2; j++) begin
      wait_pwr(1'b1, t);
      wait_pwr(1'b0, t);
      cmp_pin("open_time", 1'b1, t >= 2 * MINC && t <= 3 * MINC);
      // Buzzer follows the timeout state one edge after the valve drops
      @(negedge mclk);
      cmp_pin("buzzer", 1'b1, buzzer);
      rd(8'h1c, 32'h23, 32'h27);
      rd(8'h20, 32'h300, 32'h700);
      wr(8'h04, 32'h1);
      rd(8'h04, 32'h23, 32'h33);
      wr(8'h04, 32'h1);
      wr(8'h04, 32'h2);
      rd(8'h04, 32'h0, 32'h33);
      rd(8'h1c, 32'h0, 32'h20);
      wr(8'h04, 32'h3);
    end
    wr(8'h10, 32'd0);
    wr(8'h04, 32'h1);
    wr(8'h04, 32'h3);
    wait_pwr(1'b1, t);
    repeat (200) @(negedge mclk);
    cmp_pin("manual_open", 1'b1, valve_pwr);
    rd(8'h04, 32'h2, 32'h3);
    wr(8'h04, 32'h3);
    repeat (3) @(negedge mclk);
    cmp_pin("manual_close", 1'b0, valve_pwr);
    for (int i = 0; i < 12; i++) begin
      d1 = $random(seed);
      d2 = $random(seed);
      cf = $random(seed);
      setlv(d1[15:0], d2[15:0]);
      wr(8'h00, {29'h0, cf[2:0]});
      wr(8'h14, {14'h0, cf[5:4], d1[31:16]});
      wr(8'h18, {14'h0, cf[7:6], d2[31:16]});
      k1 = code({cf[5:4], d1[31:16]}, {1'b0, cf[2:0]}, d1[15:0], d2[15:0]);
      k2 = code({cf[7:6], d2[31:16]}, {1'b0, cf[2:0]}, d1[15:0], d2[15:0]);
      rd(8'h20, {25'h0, k2, 1'b0, k1}, 32'h77);
      @(negedge mclk);
      cmp_pin("relay1", k1 != 3'h0, relay1);
      cmp_pin("relay2", k2 != 3'h0, relay2);
      cmp_pin("buzzer", k1 != 3'h0 || k2 != 3'h0, buzzer);
    end
    setlv(16'h0100, 16'h0);
    wr(8'h00, 32'h1);
    wr(8'h18, 32'h0);
    wr(8'h14, 32'hffff);
    wr(8'h00, 32'h9);
    repeat (2) @(negedge mclk);
    cmp_pin("muted", 1'b0, buzzer);
    cmp_pin("relay1", 1'b1, relay1);
    rd(8'h1c, 32'h88, 32'h88);
    repeat (6) @(posedge mclk);
    rd(8'h1c, 32'h0, 32'h0);
    repeat (2) @(negedge mclk);
    cmp_pin("view", 1'b1, (got[$][10:8] ^ got[$-1][10:8]) == 3'h5);
    wr(8'h14, 32'h0);
    rd(8'h1c, 32'h0, 32'h88);
    wr(8'h14, 32'hffff);
    repeat (2) @(negedge mclk);
    cmp_pin("buzzer", 1'b1, buzzer);
    finish_test();
  end
endmodule // testbench
bind rvac_top rvac_monitor #(.LW(LW), .MIN_CYCLES(MIN_CYCLES)) u_mon (
  .mclk, .arst_n, .addr, .wdata, .wr_stb, .rd_stb, .rdata, .lvl_n2,
  .lvl_he, .valve_pwr, .relay1, .relay2, .buzzer);
`default_nettype wire

// ---- src/rvac_top.v ----
// Cryogen refill valve controller with two non-latching level alarms
//
// Behaviour
// - Watchdog starts with each refill; timeout alarm if stop level late.
// - Timeout alarm removes power from the fill valve output.
// - Timeout moves valve from automatic to timeout-closed, reported apart.
// - Timeout interval of zero minutes disables the watchdog completely.
// - Several alarms may be active together; every active cause is reported.
// - Alarm source is selectable with two channels, forced with only one.
// - Each alarm fires at level <= setpoint, or >= setpoint when selected.
// - Level alarms do not latch; they drop when their condition goes away.
// - Any alarm sounds the buzzer and reports low, high or timeout cause.
// - Mute silences buzzer; status view alternates cause and muted meanwhile.
// - From manual-closed one step selects automatic; commit restarts refill.
// - Parameter writes leave valve manual-closed until auto is committed.
// - Automatic state holds the level between start and stop setpoints.
// - Watchdog only for nitrogen control; trips after open time >= timeout.
// - Manual-open powers valve, manual-closed unpowers it, no overrides.
// - Mute acts on the local buzzer only; relays ignore it, status reports it.
// - Each level alarm drives its own normally open relay output.
`include "rvac_map.vh"
`default_nettype none

module rvac_top #(
  parameter LW = 16,
  parameter [39:0] MIN_CYCLES = `RVAC_MINUTE_S * `RVAC_CLK_HZ,
  parameter [39:0] BLINK_CYCLES =
    `RVAC_BLINK_MS * `RVAC_CLK_HZ / `RVAC_MS_PER_S
) (
  input wire mclk,
  input wire arst_n,
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  output reg [31:0] rdata,
  input wire [LW-1:0] lvl_n2,
  input wire [LW-1:0] lvl_he,
  output reg valve_pwr,
  output reg relay1,
  output reg relay2,
  output reg buzzer
);

  // Reset release synchroniser
  // Two stages keep a late release from meeting some flops and not others
  reg rst_s1;
  reg rst_n;
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  // Software-visible configuration
  reg dual;
  reg single_ch;
  reg fill_ch;
  reg [LW-1:0] fill_start;
  reg [LW-1:0] fill_stop;
  reg [15:0] tmo_min;
  reg [LW-1:0] sp1;
  reg [LW-1:0] sp2;
  reg src1;
  reg src2;
  reg dir1;
  reg dir2;

  // Valve state, pending selection and timing
  reg [1:0] mode;
  reg [1:0] sel;
  reg mute;
  reg [39:0] pre;
  reg [15:0] min_cnt;
  reg [39:0] blink_cnt;
  reg blink;

  // Strobe decode; parameter writes also drop the valve to manual-closed
  wire wr_ctrl = wr_stb && (addr == `RVAC_A_CTRL);
  wire wr_valve = wr_stb && (addr == `RVAC_A_VALVE);
  wire wr_param = wr_stb && ((addr == `RVAC_A_START) ||
    (addr == `RVAC_A_STOP) || (addr == `RVAC_A_TMO));

  // Effective channels: with one channel fitted every source is forced to it
  wire eff_src1 = dual ? src1 : single_ch;
  wire eff_src2 = dual ? src2 : single_ch;
  wire eff_fill = dual ? fill_ch : single_ch;
  wire [LW-1:0] lvl1 = (eff_src1 == `RVAC_CH_HE) ? lvl_he : lvl_n2;
  wire [LW-1:0] lvl2 = (eff_src2 == `RVAC_CH_HE) ? lvl_he : lvl_n2;
  wire [LW-1:0] lvl_fill = (eff_fill == `RVAC_CH_HE) ? lvl_he : lvl_n2;

  // Level alarms, evaluated afresh every cycle so nothing latches
  wire alm1 = dir1 ? (lvl1 >= sp1) : (lvl1 <= sp1);
  wire alm2 = dir2 ? (lvl2 >= sp2) : (lvl2 <= sp2);
  wire tmo_alm = (mode == `RVAC_M_TCLOSED);
  wire any_alm = alm1 || alm2 || tmo_alm;

  // Per-alarm cause codes
  wire [2:0] cause1 = !alm1 ? `RVAC_K_NONE :
    (dir1 ? `RVAC_K_HIGH : `RVAC_K_LOW);
  wire [2:0] cause2 = !alm2 ? `RVAC_K_NONE :
    (dir2 ? `RVAC_K_HIGH : `RVAC_K_LOW);
  wire [2:0] cause_t = tmo_alm ? `RVAC_K_TMO : `RVAC_K_NONE;

  // Watchdog: nitrogen control only, nonzero interval, valve open in auto
  // A zero interval holds the minute counter clear, so no trip can occur
  wire wd_on = (mode == `RVAC_M_AUTO) && valve_pwr &&
    (eff_fill == `RVAC_CH_N2) && (tmo_min != 16'h0000);
  wire minute = (pre == MIN_CYCLES - 40'd1);
  wire tmo_hit = wd_on && (min_cnt >= tmo_min);

  // Step order of the valve selector; timeout-closed leaves via manual-open
  function [1:0] rvac_step;
    input [1:0] cur;
    begin
      case (cur)
        `RVAC_M_CLOSED: rvac_step = `RVAC_M_AUTO;
        `RVAC_M_AUTO: rvac_step = `RVAC_M_OPEN;
        `RVAC_M_OPEN: rvac_step = `RVAC_M_CLOSED;
        default: rvac_step = `RVAC_M_OPEN;
      endcase
    end
  endfunction

  // Selection after an optional step; of valve writes, only a commit moves the mode
  wire [1:0] next_sel = wdata[`RVAC_V_STEP] ? rvac_step(sel) : sel;

  // Configuration registers
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dual <= `RVAC_R_DUAL;
      single_ch <= `RVAC_CH_N2;
      fill_ch <= `RVAC_CH_N2;
      fill_start <= `RVAC_R_LVL;
      fill_stop <= `RVAC_R_LVL;
      tmo_min <= `RVAC_R_TMO;
      sp1 <= `RVAC_R_LVL;
      sp2 <= `RVAC_R_LVL;
      src1 <= `RVAC_CH_N2;
      src2 <= `RVAC_CH_N2;
      dir1 <= 1'b0;
      dir2 <= 1'b0;
    end else if (wr_stb) begin
      if (addr == `RVAC_A_CTRL) begin
        dual <= wdata[`RVAC_C_DUAL];
        single_ch <= wdata[`RVAC_C_SINGLE];
        fill_ch <= wdata[`RVAC_C_FILLCH];
      end else if (addr == `RVAC_A_START) begin
        fill_start <= wdata[LW-1:0];
      end else if (addr == `RVAC_A_STOP) begin
        fill_stop <= wdata[LW-1:0];
      end else if (addr == `RVAC_A_TMO) begin
        tmo_min <= wdata[15:0];
      end else if (addr == `RVAC_A_ALM1) begin
        sp1 <= wdata[LW-1:0];
        src1 <= wdata[`RVAC_L_SRC];
        dir1 <= wdata[`RVAC_L_DIR];
      end else if (addr == `RVAC_A_ALM2) begin
        sp2 <= wdata[LW-1:0];
        src2 <= wdata[`RVAC_L_SRC];
        dir2 <= wdata[`RVAC_L_DIR];
      end
    end
  end

  // Valve state: the timeout wins over a commit in the same cycle, so a
  // trip is never hidden by an operator write racing it
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= `RVAC_M_CLOSED;
      sel <= `RVAC_M_CLOSED;
    end else if (tmo_hit) begin
      mode <= `RVAC_M_TCLOSED;
      sel <= `RVAC_M_TCLOSED;
    end else if (wr_param) begin
      mode <= `RVAC_M_CLOSED;
      sel <= `RVAC_M_CLOSED;
    end else if (wr_valve) begin
      sel <= next_sel;
      if (wdata[`RVAC_V_COMMIT]) begin
        mode <= next_sel;
      end
    end
  end

  // Valve output with start/stop hysteresis in automatic
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      valve_pwr <= 1'b0;
    end else begin
      case (mode)
        `RVAC_M_OPEN: valve_pwr <= 1'b1;
        `RVAC_M_CLOSED: valve_pwr <= 1'b0;
        `RVAC_M_TCLOSED: valve_pwr <= 1'b0;
        default: begin
          if (tmo_hit) begin
            valve_pwr <= 1'b0;
          end else if (lvl_fill >= fill_stop) begin
            valve_pwr <= 1'b0;
          end else if (lvl_fill <= fill_start) begin
            valve_pwr <= 1'b1;
          end
        end
      endcase
    end
  end

  // Minute prescaler and counter; both clear whenever the valve is shut
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pre <= 40'h0000000000;
      min_cnt <= 16'h0000;
    end else if (!wd_on) begin
      pre <= 40'h0000000000;
      min_cnt <= 16'h0000;
    end else if (minute) begin
      pre <= 40'h0000000000;
      if (min_cnt != 16'hffff) begin
        min_cnt <= min_cnt + 16'h0001;
      end
    end else begin
      pre <= pre + 40'h0000000001;
    end
  end

  // Mute holds only while some alarm is active
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mute <= 1'b0;
    end else if (!any_alm) begin
      mute <= 1'b0;
    end else if (wr_ctrl && wdata[`RVAC_C_MUTE]) begin
      mute <= 1'b1;
    end
  end

  // Blink phase for the alternating status view
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      blink_cnt <= 40'h0000000000;
      blink <= 1'b0;
    end else if (blink_cnt == BLINK_CYCLES - 40'd1) begin
      blink_cnt <= 40'h0000000000;
      blink <= !blink;
    end else begin
      blink_cnt <= blink_cnt + 40'h0000000001;
    end
  end

  // Local annunciators; relays close while their alarm stands
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      relay1 <= 1'b0;
      relay2 <= 1'b0;
      buzzer <= 1'b0;
    end else begin
      relay1 <= alm1;
      relay2 <= alm2;
      buzzer <= any_alm && !mute;
    end
  end

  // Status view code: first active cause, alternating with muted
  // Timeout goes first as it has already shut the valve
  reg [2:0] view;
  always @* begin
    view = `RVAC_K_NONE;
    if (cause_t != `RVAC_K_NONE) begin
      view = cause_t;
    end else if (cause1 != `RVAC_K_NONE) begin
      view = cause1;
    end else if (cause2 != `RVAC_K_NONE) begin
      view = cause2;
    end
    if (mute && blink) begin
      view = `RVAC_K_MUTED;
    end
  end

  // Read mux; unmapped addresses read zero
  reg [31:0] next_rdata;
  always @* begin
    next_rdata = 32'h00000000;
    if (addr == `RVAC_A_CTRL) begin
      next_rdata[`RVAC_C_DUAL] = dual;
      next_rdata[`RVAC_C_SINGLE] = single_ch;
      next_rdata[`RVAC_C_FILLCH] = fill_ch;
      next_rdata[`RVAC_C_MUTE] = mute;
    end else if (addr == `RVAC_A_VALVE) begin
      next_rdata[`RVAC_F_MODE +: 2] = mode;
      next_rdata[`RVAC_F_SEL +: 2] = sel;
    end else if (addr == `RVAC_A_START) begin
      next_rdata[LW-1:0] = fill_start;
    end else if (addr == `RVAC_A_STOP) begin
      next_rdata[LW-1:0] = fill_stop;
    end else if (addr == `RVAC_A_TMO) begin
      next_rdata[15:0] = tmo_min;
    end else if (addr == `RVAC_A_ALM1) begin
      next_rdata[LW-1:0] = sp1;
      next_rdata[`RVAC_L_SRC] = src1;
      next_rdata[`RVAC_L_DIR] = dir1;
    end else if (addr == `RVAC_A_ALM2) begin
      next_rdata[LW-1:0] = sp2;
      next_rdata[`RVAC_L_SRC] = src2;
      next_rdata[`RVAC_L_DIR] = dir2;
    end else if (addr == `RVAC_A_STAT) begin
      next_rdata[`RVAC_F_MODE +: 2] = mode;
      next_rdata[`RVAC_S_VALVE] = valve_pwr;
      next_rdata[`RVAC_S_RELAY1] = relay1;
      next_rdata[`RVAC_S_RELAY2] = relay2;
      next_rdata[`RVAC_S_TMO] = tmo_alm;
      next_rdata[`RVAC_S_BUZZ] = buzzer;
      next_rdata[`RVAC_S_MUTE] = mute;
      next_rdata[`RVAC_S_VIEW +: 3] = view;
      next_rdata[`RVAC_S_MIN +: 16] = min_cnt;
    end else if (addr == `RVAC_A_CAUSE) begin
      next_rdata[`RVAC_Q_ALM1 +: 3] = cause1;
      next_rdata[`RVAC_Q_ALM2 +: 3] = cause2;
      next_rdata[`RVAC_Q_TMO +: 3] = cause_t;
    end
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 32'h00000000;
    end else if (rd_stb) begin
      rdata <= next_rdata;
    end else begin
      rdata <= 32'h00000000;
    end
  end

endmodule // rvac_top

`default_nettype wire
